// *** hdl/core_map_regs.svh ***
// Purpose: Named constants for the address-space mapper
// Assumes: Byte-wide special registers, 24-bit memory addresses
// Notes:   Definitions only
`ifndef CORE_MAP_REGS_SVH
`define CORE_MAP_REGS_SVH
`define REGION_CODE        8'hFF
`define REGION_DATA        8'h00
`define BANK_TOP           16'h001F
`define IDATA_TOP          16'h00FF
`define SREG_LEGACY_BASE   9'h080
`define SREG_ACC           9'h0E0
`define SREG_MULDIV        9'h0F0
`define SREG_STATUS        9'h0D0
`define SREG_SP_LOW        9'h081
`define SREG_SP_HIGH       9'h0BE
`define SREG_DP_LOW        9'h082
`define SREG_DP_HIGH       9'h083
`define SREG_EXT_REGION    9'h084
`define RF_MULDIV          6'h0A
`define RF_ACC             6'h0B
`define RF_EXT_REGION      6'h39
`define RF_DP_HIGH         6'h3A
`define RF_DP_LOW          6'h3B
`define RF_SP_HIGH         6'h3E
`define RF_SP_LOW          6'h3F
`define RST_EXT_REGION     8'h01
`define RST_ZERO           8'h00
`define STATUS_BANK_HI     4
`define STATUS_BANK_LO     3
`define STATES_PER_PCYCLE  3'd6
`define PCYCLE_LAST        3'd5
`define FETCH_SLOW_CLKS    2'd3
`define FETCH_FAST_CLKS    2'd1
`define UNIMPL_READ        8'hFF
`endif

// *** hdl/core_map_pkg.sv ***
// Purpose: Types shared by the address-space mapper
// Assumes: None
// Notes:   Constants live in core_map_regs.svh
package core_map_pkg;
   typedef enum logic [1:0] {
      sp_mem  = 2'h0,
      sp_sreg = 2'h1,
      sp_rf   = 2'h2,
      sp_none = 2'h3
   } space_t;
   typedef enum logic [1:0] {
      md_native = 2'h0,
      md_code   = 2'h1,
      md_xdata  = 2'h2,
      md_idata  = 2'h3
   } access_mode_t;
   typedef struct packed {
      logic         valid;
      logic         write;
      space_t       space;
      access_mode_t mode;
      logic         direct;
      logic         bit_access;
      logic [2:0]   bit_index;
      logic [1:0]   size;
      logic [23:0]  addr;
      logic [7:0]   wdata;
   } access_req_t;
   typedef struct packed {
      logic        to_mem;
      logic        to_sreg;
      logic        to_rf;
      logic [23:0] mem_addr;
      logic [8:0]  sreg_addr;
      logic [5:0]  rf_index;
   } target_t;
   typedef enum logic [1:0] {
      f_idle  = 2'b00,
      f_wait  = 2'b01,
      f_done  = 2'b11
   } fetch_state_t;
endpackage

// *** hdl/clock_phase_gen.sv ***
// Purpose: State, phase and peripheral-cycle timing generator
// Assumes: One oscillator period per i_clk edge
// Notes:   Drives phase markers only; never gates the clock
`timescale 1ns/10ps
`include "core_map_regs.svh"
module clock_phase_gen (
   input  wire logic       i_clk,
   input  wire logic       i_nrst,
   output logic            o_second_half_phase,
   output logic [2:0]      o_state_num,
   output logic            o_pcycle_end
);
   import core_map_pkg::*;
   logic       phase;
   logic [2:0] state_num;
   logic       next_phase;
   logic [2:0] next_state_num;
   // ----------------------------------------------------------------
   // Phase and state counters
   // ----------------------------------------------------------------
   // Two clocks make a state, six states a peripheral cycle
   always_comb begin
      next_phase     = ~phase;
      next_state_num = state_num;
      if (phase) begin
         next_state_num = (state_num == `PCYCLE_LAST) ? 3'd0
                          : state_num + 3'd1;
      end
   end
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         phase     <= 1'b0;
         state_num <= 3'd0;
      end else begin
         phase     <= next_phase;
         state_num <= next_state_num;
      end
   end
   assign o_second_half_phase = phase;
   assign o_state_num         = state_num;
   assign o_pcycle_end        = phase && (state_num == `PCYCLE_LAST);
endmodule // clock_phase_gen

// *** hdl/core_address_space_mapper.sv ***
// Purpose: Address-space decode, shared core registers and fetch timing
// Assumes: Reset pin and watchdog timeout arrive asynchronously
// Notes:   Bank bytes live in on-chip RAM; this block only forms addresses
`timescale 1ns/10ps
`include "core_map_regs.svh"
// Operation
// - Code fetched two bytes on-chip, one byte external, over 16-bit bus.
// - Page-mode external fetch in same 256-byte page takes two clocks, else four.
// - A state is two oscillator periods, split into two phases.
// - Peripherals run on a six-state cycle indexed by state and phase.
// - Full pipeline: one instruction per state on-chip, two external.
// - Reset pin or watchdog timeout puts the device into known state; watchdog leaves the phase generator running.
// - Granted interrupt branches; trap and non-maskable unmaskable; four levels.
// - Memory is linear 24-bit, 256 regions of 64 Kbytes, no segments.
// - On-chip code lives in region FF, on-chip RAM starts at 00:0000h.
// - Register locations 0-7 are a bank, also memory 00:0000h-00:001Fh.
// - Register locations 8-63 never answer any memory address.
// - Status byte bits pick the active register bank.
// - Two select bits choose banks at 00h, 08h, 10h, 18h.
// - 512 byte-wide special registers decoded apart from memory.
// - Unimplemented special registers read unspecified; byte access only.
// - External data moves use region byte, reset 01h, also location 57, S:084h.
// - Legacy code and code-read data go to region FF.
// - Legacy internal data maps to 00:0000h-00:00FFh; native any mode.
// - Legacy direct 80h-FFh selects special registers; indirect selects memory.
// - Legacy special registers sit unchanged from S:080h, bit access kept.
// - Core registers share storage between register file and special-register view.
module core_address_space_mapper (
   input  wire logic                      i_clk,
   input  wire logic                      i_nrst,
   input  wire logic                      i_wdt_timeout,
   input  wire logic                      i_page_mode,
   input  wire logic                      i_fetch_req,
   input  wire logic [23:0]               i_fetch_addr,
   input  wire logic [15:0]               i_mem_rdata,
   input  wire logic [7:0]                i_irq_req,
   input  wire logic [7:0]                i_irq_enable,
   input  wire logic [15:0]               i_irq_level,
   input  wire logic                      i_nmi,
   input  wire logic                      i_trap,
   input  wire core_map_pkg::access_req_t i_req,
   output core_map_pkg::target_t          o_target,
   output logic                           o_req_error,
   output logic [7:0]                     o_sreg_rdata,
   output logic [15:0]                    o_instr_bus,
   output logic                           o_instr_valid,
   output logic                           o_fetch_ext,
   output logic                           o_retire_slot,
   output logic                           o_irq_grant,
   output logic [3:0]                     o_irq_source,
   output logic [1:0]                     o_irq_level,
   output logic                           o_core_reset,
   output logic                           o_second_half_phase,
   output logic [2:0]                     o_state_num,
   output logic                           o_pcycle_end,
   output logic [1:0]                     o_active_bank
);
   import core_map_pkg::*;

   // ----------------------------------------------------------------
   // Reset: pin plus watchdog, synchronised on release
   // ----------------------------------------------------------------
   logic wdt_meta, wdt_sync, rst_meta, rst_sync;
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {rst_meta, rst_sync, wdt_meta, wdt_sync} <= 4'h0;
      end else begin
         {rst_meta, rst_sync} <= {1'b1, rst_meta};
         {wdt_meta, wdt_sync} <= {i_wdt_timeout, wdt_meta};
      end
   end
   // Watchdog timeout resets core registers and fetch like the pin; the phase generator keeps running
   logic soft_rst;
   assign soft_rst     = !rst_sync || wdt_sync;
   assign o_core_reset = soft_rst;

   clock_phase_gen u_phase (
      .i_clk               (i_clk),
      .i_nrst              (i_nrst),
      .o_second_half_phase (o_second_half_phase),
      .o_state_num         (o_state_num),
      .o_pcycle_end        (o_pcycle_end)
   );

   // ----------------------------------------------------------------
   // Shared core registers (one storage, two views)
   // ----------------------------------------------------------------
   logic [7:0] acc, muldiv, status, sp_lo, sp_hi, dp_lo, dp_hi, ext_data_region_byte;
   logic [7:0] next_acc, next_muldiv, next_status, next_sp_lo, next_sp_hi;
   logic [7:0] next_dp_lo, next_dp_hi, next_ext_data_region_byte;
   logic [5:0] rf_idx;
   logic [8:0] sr_idx;
   logic       wr_rf, wr_sr;

   // Byte write with optional single-bit update for bit addressing
   function automatic logic [7:0] merge(input logic [7:0] old, input access_req_t r);
      logic [7:0] v;
      v = r.bit_access ? old : r.wdata;
      if (r.bit_access) v[r.bit_index] = r.wdata[0];
      return v;
   endfunction
   // Write hit on a shared byte through either of its two addresses
   function automatic logic hit(input logic [5:0] r, input logic [8:0] s);
      return (wr_rf && rf_idx == r) || (wr_sr && sr_idx == s);
   endfunction

   always_comb begin
      {next_acc, next_muldiv, next_status, next_sp_lo} = {acc, muldiv, status, sp_lo};
      {next_sp_hi, next_dp_lo, next_dp_hi} = {sp_hi, dp_lo, dp_hi};
      next_ext_data_region_byte = ext_data_region_byte;
      // Either view lands on the same flip-flops
      if (hit(`RF_ACC, `SREG_ACC)) next_acc = merge(acc, i_req);
      if (hit(`RF_MULDIV, `SREG_MULDIV)) next_muldiv = merge(muldiv, i_req);
      if (wr_sr && sr_idx == `SREG_STATUS) next_status = merge(status, i_req);
      if (hit(`RF_SP_LOW, `SREG_SP_LOW)) next_sp_lo = merge(sp_lo, i_req);
      if (hit(`RF_SP_HIGH, `SREG_SP_HIGH)) next_sp_hi = merge(sp_hi, i_req);
      if (hit(`RF_DP_LOW, `SREG_DP_LOW)) next_dp_lo = merge(dp_lo, i_req);
      if (hit(`RF_DP_HIGH, `SREG_DP_HIGH)) next_dp_hi = merge(dp_hi, i_req);
      if (hit(`RF_EXT_REGION, `SREG_EXT_REGION))
         next_ext_data_region_byte = merge(ext_data_region_byte, i_req);
      // Watchdog reset restores the same values as the pin
      if (soft_rst) begin
         {next_acc, next_muldiv, next_status, next_sp_lo} = {4{`RST_ZERO}};
         {next_sp_hi, next_dp_lo, next_dp_hi} = {3{`RST_ZERO}};
         next_ext_data_region_byte = `RST_EXT_REGION;
      end
   end

   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         {acc, muldiv, status, sp_lo} <= {4{`RST_ZERO}};
         {sp_hi, dp_lo, dp_hi}        <= {3{`RST_ZERO}};
         ext_data_region_byte         <= `RST_EXT_REGION;
      end else begin
         {acc, muldiv, status, sp_lo} <= {next_acc, next_muldiv, next_status, next_sp_lo};
         {sp_hi, dp_lo, dp_hi}        <= {next_sp_hi, next_dp_lo, next_dp_hi};
         ext_data_region_byte         <= next_ext_data_region_byte;
      end
   end

   // Bank select bits of the status byte
   assign o_active_bank = {status[`STATUS_BANK_HI], status[`STATUS_BANK_LO]};

   // ----------------------------------------------------------------
   // Address decode: at most one target per access, none on error
   // ----------------------------------------------------------------
   target_t tgt;
   logic    err;
   always_comb begin
      tgt    = '0;
      err    = 1'b0;
      if (i_req.valid) begin
         case (i_req.mode)
            md_code: begin
               tgt.to_mem   = 1'b1;
               tgt.mem_addr = {`REGION_CODE, i_req.addr[15:0]};
            end
            md_xdata: begin
               tgt.to_mem   = 1'b1;
               tgt.mem_addr = {ext_data_region_byte, i_req.addr[15:0]};
            end
            md_idata: begin
               // Upper half direct goes to the legacy register window
               if (i_req.direct && i_req.addr[7]) begin
                  tgt.to_sreg   = 1'b1;
                  tgt.sreg_addr = {1'b0, i_req.addr[7:0]};
               end else begin
                  tgt.to_mem   = 1'b1;
                  tgt.mem_addr = {`REGION_DATA, 8'h00, i_req.addr[7:0]};
               end
            end
            default: begin
               case (i_req.space)
                  sp_mem: begin
                     tgt.to_mem   = 1'b1;
                     tgt.mem_addr = i_req.addr;
                  end
                  sp_sreg: begin
                     tgt.to_sreg   = 1'b1;
                     tgt.sreg_addr = i_req.addr[8:0];
                  end
                  sp_rf: begin
                     if (i_req.addr[5:3] == 3'b000) begin
                        // Banked slot becomes a RAM byte in region 00
                        tgt.to_mem   = 1'b1;
                        tgt.mem_addr = {`REGION_DATA, 11'h000,
                                        o_active_bank, i_req.addr[2:0]};
                     end else begin
                        tgt.to_rf    = 1'b1;
                        tgt.rf_index = i_req.addr[5:0];
                     end
                  end
                  default: err = 1'b1;
               endcase
            end
         endcase
         // Special registers are byte-only
         if (tgt.to_sreg && i_req.size != 2'd0) begin
            tgt = '0;
            err = 1'b1;
         end
      end
      rf_idx = tgt.rf_index;
      sr_idx = tgt.sreg_addr;
   end
   assign wr_rf       = tgt.to_rf && i_req.write && !soft_rst;
   assign wr_sr       = tgt.to_sreg && i_req.write && !soft_rst;
   assign o_target    = tgt;
   assign o_req_error = err;

   // Special-register read view of shared storage
   always_comb begin
      case (sr_idx)
         `SREG_ACC:        o_sreg_rdata = acc;
         `SREG_MULDIV:     o_sreg_rdata = muldiv;
         `SREG_STATUS:     o_sreg_rdata = status;
         `SREG_SP_LOW:     o_sreg_rdata = sp_lo;
         `SREG_SP_HIGH:    o_sreg_rdata = sp_hi;
         `SREG_DP_LOW:     o_sreg_rdata = dp_lo;
         `SREG_DP_HIGH:    o_sreg_rdata = dp_hi;
         `SREG_EXT_REGION: o_sreg_rdata = ext_data_region_byte;
         default:          o_sreg_rdata = `UNIMPL_READ;
      endcase
   end

   // ----------------------------------------------------------------
   // Instruction fetch timing
   // ----------------------------------------------------------------
   fetch_state_t fstate, next_fstate;
   logic [1:0]   fcnt, next_fcnt;
   logic [15:0]  last_page, next_last_page;
   logic         page_ok, next_page_ok;
   logic [15:0]  ibus, next_ibus;
   logic         ext, next_ext;
   logic         onchip;
   assign onchip = (i_fetch_addr[23:16] == `REGION_CODE);
   always_comb begin
      next_fstate = fstate;
      {next_fcnt, next_last_page, next_page_ok, next_ibus, next_ext} =
         {fcnt, last_page, page_ok, ibus, ext};
      case (fstate)
         f_idle: begin
            if (i_fetch_req) begin
               next_ext = !onchip;
               // Same 256-byte page in page mode halves the external fetch
               if (onchip || (i_page_mode && page_ok &&
                              i_fetch_addr[23:8] == last_page))
                  next_fcnt = `FETCH_FAST_CLKS;
               else
                  next_fcnt = `FETCH_SLOW_CLKS;
               next_last_page = i_fetch_addr[23:8];
               next_page_ok   = !onchip;
               next_fstate    = f_wait;
            end
         end
         f_wait: begin
            if (fcnt == 2'd1) begin
               // On-chip gives a word, external one byte in the low lane
               next_ibus   = ext ? {8'h00, i_mem_rdata[7:0]} : i_mem_rdata;
               next_fstate = f_done;
            end else begin
               next_fcnt = fcnt - 2'd1;
            end
         end
         default: next_fstate = f_idle;
      endcase
      // Core reset drops a fetch in flight and forgets the page
      if (soft_rst) begin
         next_fstate  = f_idle;
         next_page_ok = 1'b0;
         next_ext     = 1'b0;
      end
   end
   always_ff @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         fstate <= f_idle;
         {fcnt, last_page, page_ok, ibus, ext} <= '0;
      end else begin
         fstate <= next_fstate;
         {fcnt, last_page, page_ok, ibus, ext} <=
            {next_fcnt, next_last_page, next_page_ok, next_ibus, next_ext};
      end
   end
   assign o_instr_bus   = ibus;
   assign o_instr_valid = (fstate == f_done);
   assign o_fetch_ext   = ext;
   assign o_retire_slot = (fstate == f_done);

   // ----------------------------------------------------------------
   // Interrupt grant summary
   // ----------------------------------------------------------------
   logic [1:0] best_lvl;
   logic [3:0] best_src;
   logic       any;
   always_comb begin
      best_lvl = 2'd0;
      best_src = 4'd0;
      any      = 1'b0;
      // Highest level wins; lower index wins a tie
      for (int k = 7; k >= 0; k--) begin
         if (i_irq_req[k] && i_irq_enable[k] &&
             (!any || i_irq_level[2*k +: 2] >= best_lvl)) begin
            any      = 1'b1;
            best_lvl = i_irq_level[2*k +: 2];
            best_src = 4'(k);
         end
      end
      // Trap and non-maskable ignore enables
      if (i_trap) {any, best_lvl, best_src} = {1'b1, 2'd3, 4'd9};
      if (i_nmi) {any, best_lvl, best_src} = {1'b1, 2'd3, 4'd8};
   end
   assign o_irq_grant  = any && !soft_rst;
   assign o_irq_source = best_src;
   assign o_irq_level  = best_lvl;
endmodule // core_address_space_mapper

// *** sim/core_map_asserts.sv ***
// Purpose: Port checks for the address mapper
// Assumes: One clock, reset active low
// Notes:   Bound to every mapper instance
`timescale 1ns/10ps
`include "core_map_regs.svh"
module core_map_asserts (
   input wire logic                      i_clk,
   input wire logic                      i_nrst,
   input wire logic                      i_wdt_timeout,
   input wire core_map_pkg::access_req_t i_req,
   input wire core_map_pkg::target_t     o_target,
   input wire logic                      o_req_error,
   input wire logic                      o_core_reset,
   input wire logic                      o_second_half_phase,
   input wire logic [2:0]                o_state_num,
   input wire logic                      o_pcycle_end,
   input wire logic [1:0]                o_active_bank
);
   import core_map_pkg::*;
   logic mem_rq;
   logic rf_rq;
   // Request kinds, kept apart so the properties stay short
   assign mem_rq = i_req.valid && i_req.space == sp_mem;
   assign rf_rq  = i_req.valid && i_req.space == sp_rf && i_req.mode == md_native;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_nrst);
   // ----------------------------------------
   // Decode and timing properties
   // ----------------------------------------
   a_one_target:
      assert property ($onehot0({o_target.to_mem, o_target.to_sreg, o_target.to_rf}))
      else $error("two targets at once");
   a_phase_alt:
      assert property (o_second_half_phase |=> !o_second_half_phase)
      else $error("second phase held");
   a_pcycle_last:
      assert property (o_pcycle_end |-> o_state_num == `PCYCLE_LAST)
      else $error("peripheral cycle ends early");
   a_bank_map:
      assert property (rf_rq && i_req.addr[5:3] == 3'h0 |-> o_target.to_mem
         && o_target.mem_addr == {19'h0, o_active_bank, i_req.addr[2:0]})
      else $error("bank byte misplaced");
   a_rf_private:
      assert property (rf_rq && i_req.addr[5:3] != 3'h0 |-> o_target.to_rf && !o_target.to_mem)
      else $error("register answers memory");
   a_code_region:
      assert property (mem_rq && i_req.mode == md_code |->
         o_target.mem_addr == {`REGION_CODE, i_req.addr[15:0]})
      else $error("code read outside code region");
   a_region_write:
      assert property (i_req.valid && i_req.write && i_req.space == sp_sreg
         && i_req.addr[8:0] == `SREG_EXT_REGION && i_req.size == 2'h0 && !o_core_reset
         && !i_req.bit_access && i_req.mode == md_native
         ##1 mem_rq && i_req.mode == md_xdata
         |-> o_target.mem_addr == {$past(i_req.wdata), i_req.addr[15:0]})
      else $error("region byte not applied");
   a_direct_high:
      assert property (mem_rq && i_req.mode == md_idata && i_req.direct && i_req.addr[7]
         |-> o_target.to_sreg && o_target.sreg_addr == {1'b0, i_req.addr[7:0]})
      else $error("direct upper byte not special");
   a_sreg_bytes:
      assert property (i_req.valid && i_req.space == sp_sreg && i_req.size != 2'h0
         && i_req.mode == md_native
         |-> o_req_error && !o_target.to_sreg)
      else $error("wide special access taken");
   a_wdt_reset:
      assert property (i_wdt_timeout [*4] |-> o_core_reset)
      else $error("watchdog ignored");
   a_reset_release:
      assert property ($rose(i_nrst) |-> o_core_reset)
      else $error("core reset dropped early");
endmodule // core_map_asserts
bind core_address_space_mapper core_map_asserts core_map_asserts_i (.*);

// *** sim/ext_memory_model.sv ***
// Purpose: Far-side memory answering instruction fetches
// Assumes: Address held until the word is handed on
// Notes:   Outside a fetch the data lines wander
`timescale 1ns/10ps
module ext_memory_model (
   input  wire logic        i_clk,
   input  wire logic        i_nrst,
   input  wire logic        i_fetch_req,
   input  wire logic [23:0] i_fetch_addr,
   input  wire logic        i_instr_valid,
   output logic [15:0]      o_mem_rdata
);
   logic        busy;
   logic [15:0] noise;
   // Open from request to delivery; released lines never look stable
   always @(posedge i_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         busy  <= 1'b0;
         noise <= 16'h0000;
      end else begin
         noise <= noise + 16'h3B1D;
         if (i_fetch_req)
            busy <= 1'b1;
         else if (i_instr_valid)
            busy <= 1'b0;
      end
   end
   // Word content follows the address; external side uses low byte
   assign o_mem_rdata = busy ? {i_fetch_addr[7:0] ^ 8'h5A, i_fetch_addr[15:8]
      ^ i_fetch_addr[23:16]} : noise;
endmodule // ext_memory_model

// *** sim/core_address_space_mapper_tb.sv ***
// Purpose: Self-checking bench for the address mapper
// Assumes: Fixed seed, partner answers at once
// Notes:   Decode checks sampled mid-cycle
`timescale 1ns/10ps
`include "core_map_regs.svh"
`define CHK(n, e, g) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("MISMATCH %s exp %0h got %0h", n, e, g); end end
module core_address_space_mapper_tb;
   import core_map_pkg::*;
   logic        i_clk = 1'b0, i_nrst = 1'b0, i_wdt_timeout = 1'b0, i_page_mode = 1'b0;
   logic        i_fetch_req = 1'b0, i_nmi = 1'b0, i_trap = 1'b0;
   logic [23:0] i_fetch_addr = 24'h0;
   logic [7:0]  i_irq_req = 8'h0, i_irq_enable = 8'h0;
   logic [15:0] i_irq_level = 16'h0;
   logic [15:0] i_mem_rdata;
   access_req_t i_req = '0;
   target_t     o_target;
   logic        o_req_error, o_instr_valid, o_retire_slot, o_irq_grant, o_core_reset;
   logic        o_pcycle_end, o_fetch_ext;
   logic [7:0]  o_sreg_rdata;
   logic [15:0] o_instr_bus;
   logic [3:0]  o_irq_source;
   logic [1:0]  o_active_bank;
   int          err_total = 0;
   int          total_checks = 0;
   int          n;
   logic        prev_ext = 1'b0;
   logic [15:0] prev_page = 16'h0;
   logic [7:0]  v;
   logic [23:0] a;
   logic [5:0]  rfs[7] = '{6'h0A, 6'h0B, 6'h39, 6'h3A, 6'h3B, 6'h3E, 6'h3F};
   logic [8:0]  srs[7] = '{9'h0F0, 9'h0E0, 9'h084, 9'h083, 9'h082, 9'h0BE, 9'h081};
   always #5 i_clk = ~i_clk;
   core_address_space_mapper core_address_space_mapper_i (.*, .o_irq_level(),
      .o_second_half_phase(), .o_state_num());
   ext_memory_model ext_memory_model_i (.i_clk, .i_nrst, .i_fetch_req, .i_fetch_addr,
      .i_instr_valid(o_instr_valid), .o_mem_rdata(i_mem_rdata));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   // One access per cycle; decode answer looked at mid-cycle
   task automatic acc(input logic w, space_t s, access_mode_t m, logic d, logic [1:0] z,
                      logic [23:0] ad, logic [7:0] wd);
      @(posedge i_clk);
      i_req <= '{1'b1, w, s, m, d, 1'b0, 3'h0, z, ad, wd};
      @(negedge i_clk);
   endtask
   // Fetch; latency follows page history
   task automatic fetch(input logic [23:0] fa, logic pm);
      int lat;
      logic [15:0] mask;
      lat = (fa[23:16] == `REGION_CODE || (pm && prev_ext && prev_page == fa[23:8])) ? 2 : 4;
      mask = (fa[23:16] == `REGION_CODE) ? 16'hFFFF : 16'h00FF;
      @(posedge i_clk);
      i_fetch_req <= 1'b1;
      i_fetch_addr <= fa;
      i_page_mode <= pm;
      @(posedge i_clk);
      i_fetch_req <= 1'b0;
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (!o_instr_valid && n < 9);
      `CHK("fetch clocks", lat, n)
      `CHK("fetch side", fa[23:16] != `REGION_CODE, o_fetch_ext)
      `CHK("instr data", {fa[7:0] ^ 8'h5A, fa[15:8] ^ fa[23:16]} & mask, o_instr_bus & mask)
      `CHK("retire slot", 1'b1, o_retire_slot)
      prev_ext = fa[23:16] != `REGION_CODE;
      prev_page = fa[23:8];
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Watchdog: run needs some 450 cycles, allow twenty thousand
   initial begin
      #200000;
      err_total++;
      finish_test();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      void'($urandom(41850));
      repeat (20) @(posedge i_clk);
      i_nrst <= 1'b1;
      repeat (3) @(posedge i_clk);
      acc(0, sp_sreg, md_native, 0, 0, `SREG_EXT_REGION, 0);
      `CHK("region reset", `RST_EXT_REGION, o_sreg_rdata)
      for (int k = 0; k < 7; k++) begin
         v = $urandom;
         acc(1, sp_rf, md_native, 0, 0, rfs[k], v);
         acc(0, sp_sreg, md_native, 0, 0, srs[k], 0);
         `CHK("shared byte", v, o_sreg_rdata)
      end
      v = $urandom;
      a = $urandom;
      acc(1, sp_sreg, md_native, 0, 0, `SREG_EXT_REGION, v);
      acc(0, sp_mem, md_xdata, 0, 0, a, 0);
      `CHK("xdata addr", {v, a[15:0]}, o_target.mem_addr)
      for (int b = 0; b < 4; b++) begin
         a = $urandom % 8;
         acc(1, sp_sreg, md_native, 0, 0, `SREG_STATUS, 8'(b << 3));
         acc(0, sp_rf, md_native, 0, 0, a, 0);
         `CHK("bank", 2'(b), o_active_bank)
         `CHK("bank addr", {19'h0, 2'(b), a[2:0]}, o_target.mem_addr)
      end
      repeat (40) begin
         a = $urandom;
         acc(0, sp_mem, md_code, 0, 0, a, 0);
         `CHK("code addr", {`REGION_CODE, a[15:0]}, o_target.mem_addr)
         acc(0, sp_mem, md_idata, 1, 0, a[7:0], 0);
         `CHK("direct target", a[7] ? 3'h2 : 3'h4, o_target[41:39])
         acc(0, sp_mem, md_idata, 0, 0, a[7:0], 0);
         `CHK("indirect addr", {16'h0, a[7:0]}, o_target.mem_addr)
         acc(0, sp_rf, md_native, 0, 0, 8 + a % 56, 0);
         `CHK("rf target", 3'h1, o_target[41:39])
         acc(0, sp_mem, md_native, 0, 0, a, 0);
         `CHK("linear addr", a, o_target.mem_addr)
      end
      acc(1, sp_sreg, md_native, 0, 1, `SREG_EXT_REGION, 8'h77);
      `CHK("wide special", 1'b1, o_req_error)
      acc(0, sp_none, md_native, 0, 0, 0, 0);
      `CHK("no space", 1'b1, o_req_error)
      acc(0, sp_sreg, md_native, 0, 0, `SREG_EXT_REGION, 0);
      `CHK("refused write", v, o_sreg_rdata)
      @(posedge i_clk) i_req <= '0;
      $display("decode tests done");
      fetch(24'h012340, 1);
      fetch(24'h012341, 1);
      fetch(24'h012400, 1);
      fetch(24'hFF0010, 1);
      fetch(24'h012401, 1);
      fetch(24'h012402, 0);
      repeat (30) begin
         a = $urandom;
         if ($urandom % 2)
            a[23:8] = prev_page;
         fetch(a, 1'($urandom));
      end
      $display("fetch tests done");
      n = 0;
      while (!o_pcycle_end && n < 20) begin
         @(negedge i_clk);
         n++;
      end
      n = 0;
      do begin
         @(negedge i_clk);
         n++;
      end while (!o_pcycle_end && n < 20);
      `CHK("pcycle clocks", 12, n)
      @(posedge i_clk) i_irq_req <= 8'h01;
      @(negedge i_clk);
      `CHK("masked irq", 1'b0, o_irq_grant)
      @(posedge i_clk) i_nmi <= 1'b1;
      @(negedge i_clk);
      `CHK("nmi source", 4'h8, o_irq_source)
      @(posedge i_clk) i_wdt_timeout <= 1'b1;
      repeat (5) @(negedge i_clk);
      `CHK("wdt reset", 1'b1, o_core_reset)
      @(posedge i_clk) i_wdt_timeout <= 1'b0;
      repeat (6) @(posedge i_clk);
      acc(0, sp_sreg, md_native, 0, 0, `SREG_EXT_REGION, 0);
      `CHK("region after wdt", `RST_EXT_REGION, o_sreg_rdata)
      $display("timing and reset tests done");
      finish_test();
   end
endmodule // core_address_space_mapper_tb
